// ### hw/dcfg_regs.sv
// Output, sync and error-protection configuration register bank.
// Assumes a byte register port from the control-channel decoder; straps sampled
// synchronously and captured on the first enabled edge after reset release.
`timescale 1ns/1ps
module dcfg_regs
  import dcfg_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic en_i,
  // Configuration pins
  input wire logic local_control_enable_pin_i,
  input wire logic edge_config_pin_i,
  input wire logic sync_config_pin_i,
  input wire logic protect_config_pin_i,
  input wire logic double_config_pin_i,
  // Register port
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  // Link error events
  input wire logic det_err_i,
  input wire logic cor_err_i,
  // Video path
  input wire logic vsync_i,
  input wire logic hsync_i,
  input wire logic [1:0] data_low_i,
  output logic vsync_o,
  output logic hsync_o,
  output logic output_bit_zero_o,
  output logic output_bit_one_o,
  // Configuration outputs
  output logic edge_select_o,
  output logic sync_tracking_enable_o,
  output logic sync_encoding_enable_o,
  output logic [1:0] error_protect_select_o,
  output logic [4:0] interleave_words_o,
  output logic double_mode_o,
  output logic double_mode_equal_o,
  output logic stagger_disable_o,
  output logic error_o,
  // I2C address translation
  input wire logic xl_valid_i,
  input wire logic [6:0] xl_addr_i,
  output logic xl_valid_o,
  output logic [6:0] xl_addr_o
);
  logic strap_done_ff;
  logic [7:0] mode_ff;
  logic [7:0] osp_ff;
  logic [7:0] inv_ff;
  logic [6:0] src_a_ff, dst_a_ff, src_b_ff, dst_b_ff;
  logic [7:0] det_thr_ff, cor_thr_ff;
  logic [7:0] det_cnt_ff, cor_cnt_ff;
  logic [7:0] nxt_rdata;
  logic nxt_err;
  logic clr_cnt;
  logic [6:0] clr_cyc_ff;
  dcfg_clr_state_t clr_st_ff;

  function automatic logic wr_hit(input logic [7:0] a);
    return reg_wr_i && (reg_addr_i == a);
  endfunction

  // Straps win only with local control low
  logic strap_ok;
  assign strap_ok = !local_control_enable_pin_i;

  // Config registers; straps load once, since reset flops take constants only
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      strap_done_ff <= 1'b0;
      mode_ff <= DCFG_RST_ZERO;
      osp_ff <= DCFG_RST_ZERO;
    end else if (en_i) begin
      if (!strap_done_ff) begin
        strap_done_ff <= 1'b1;
        mode_ff[DCFG_DBL_BIT] <= strap_ok && double_config_pin_i;
        osp_ff[DCFG_ES_BIT] <= strap_ok && edge_config_pin_i;
        osp_ff[DCFG_TRK_BIT] <= strap_ok && sync_config_pin_i;
        osp_ff[DCFG_ENC_BIT] <= strap_ok && sync_config_pin_i;
        osp_ff[1:0] <= (strap_ok && protect_config_pin_i) ? DCFG_EDC_HAMMING
                                                         : DCFG_EDC_PARITY;
      end else begin
        if (wr_hit(DCFG_ADDR_MODE)) begin
          mode_ff[DCFG_DBL_BIT] <= reg_wdata_i[DCFG_DBL_BIT];
        end
        if (wr_hit(DCFG_ADDR_OSP)) begin
          osp_ff <= {3'h0, reg_wdata_i[4:0]};
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      inv_ff <= DCFG_RST_ZERO;
      src_a_ff <= 7'h00;
      dst_a_ff <= 7'h00;
      src_b_ff <= 7'h00;
      dst_b_ff <= 7'h00;
      det_thr_ff <= DCFG_RST_ZERO;
      cor_thr_ff <= DCFG_RST_ZERO;
    end else if (en_i) begin
      if (wr_hit(DCFG_ADDR_INV)) begin
        inv_ff <= {reg_wdata_i[7:6], 1'b0, reg_wdata_i[4:0]};
      end
      if (wr_hit(DCFG_ADDR_SRCA)) begin
        src_a_ff <= reg_wdata_i[7:1];
      end
      if (wr_hit(DCFG_ADDR_DSTA)) begin
        dst_a_ff <= reg_wdata_i[7:1];
      end
      if (wr_hit(DCFG_ADDR_SRCB)) begin
        src_b_ff <= reg_wdata_i[7:1];
      end
      if (wr_hit(DCFG_ADDR_DSTB)) begin
        dst_b_ff <= reg_wdata_i[7:1];
      end
      if (wr_hit(DCFG_ADDR_DETTH)) begin
        det_thr_ff <= reg_wdata_i;
      end
      if (wr_hit(DCFG_ADDR_CORTH)) begin
        cor_thr_ff <= reg_wdata_i;
      end
    end
  end

  // Saturating counters; clear beats a same-cycle increment
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      det_cnt_ff <= DCFG_RST_ZERO;
      cor_cnt_ff <= DCFG_RST_ZERO;
    end else if (en_i) begin
      if (clr_cnt) begin
        det_cnt_ff <= DCFG_RST_ZERO;
        cor_cnt_ff <= DCFG_RST_ZERO;
      end else begin
        if (det_err_i && det_cnt_ff != 8'hFF) begin
          det_cnt_ff <= det_cnt_ff + 8'h01;
        end
        if (cor_err_i && cor_cnt_ff != 8'hFF) begin
          cor_cnt_ff <= cor_cnt_ff + 8'h01;
        end
      end
    end
  end

  // Error output source
  always_comb begin
    case (inv_ff[1:0])
      DCFG_ERROR_OUTPUT_SELECT_DET: nxt_err = det_cnt_ff > det_thr_ff;
      DCFG_ERROR_OUTPUT_SELECT_COR: nxt_err = cor_cnt_ff > cor_thr_ff;
      default: nxt_err = (det_cnt_ff > det_thr_ff) || (cor_cnt_ff > cor_thr_ff);
    endcase
  end

  // Auto-clear timer starts when the error output is asserted
  assign clr_cnt = (clr_st_ff == DCFG_ST_WAIT) &&
                   (clr_cyc_ff == 7'(DCFG_AUTOCLR_CYC - 1));
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      clr_st_ff <= DCFG_ST_IDLE;
      clr_cyc_ff <= 7'h00;
    end else if (en_i) begin
      case (clr_st_ff)
        DCFG_ST_IDLE: begin
          clr_cyc_ff <= 7'h00;
          if (error_o && inv_ff[DCFG_AUTO_BIT]) begin
            clr_st_ff <= DCFG_ST_WAIT;
          end
        end
        DCFG_ST_WAIT: begin
          clr_cyc_ff <= clr_cyc_ff + 7'h01;
          if (!inv_ff[DCFG_AUTO_BIT]) begin
            clr_st_ff <= DCFG_ST_IDLE;
          end else if (clr_cnt) begin
            clr_st_ff <= DCFG_ST_HOLD;
          end
        end
        DCFG_ST_HOLD: begin
          // Wait for the error output to fall before rearming
          if (!error_o) begin
            clr_st_ff <= DCFG_ST_IDLE;
          end
        end
        default: clr_st_ff <= DCFG_ST_IDLE;
      endcase
    end
  end

  // Read mux
  always_comb begin
    case (reg_addr_i)
      DCFG_ADDR_MODE: nxt_rdata = mode_ff;
      DCFG_ADDR_OSP: nxt_rdata = osp_ff;
      DCFG_ADDR_INV: nxt_rdata = inv_ff;
      DCFG_ADDR_SRCA: nxt_rdata = {src_a_ff, 1'b0};
      DCFG_ADDR_DSTA: nxt_rdata = {dst_a_ff, 1'b0};
      DCFG_ADDR_SRCB: nxt_rdata = {src_b_ff, 1'b0};
      DCFG_ADDR_DSTB: nxt_rdata = {dst_b_ff, 1'b0};
      DCFG_ADDR_DETTH: nxt_rdata = det_thr_ff;
      DCFG_ADDR_DETCNT: nxt_rdata = det_cnt_ff;
      DCFG_ADDR_CORTH: nxt_rdata = cor_thr_ff;
      DCFG_ADDR_CORCNT: nxt_rdata = cor_cnt_ff;
      default: nxt_rdata = DCFG_RST_ZERO;
    endcase
  end

  // Registered outputs
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reg_rdata_o <= DCFG_RST_ZERO;
      reg_rvalid_o <= 1'b0;
      error_o <= 1'b0;
      edge_select_o <= 1'b0;
      sync_tracking_enable_o <= 1'b0;
      sync_encoding_enable_o <= 1'b0;
      error_protect_select_o <= DCFG_EDC_PARITY;
      interleave_words_o <= 5'h00;
      double_mode_o <= 1'b0;
      double_mode_equal_o <= 1'b0;
      stagger_disable_o <= 1'b0;
    end else if (en_i) begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        reg_rdata_o <= nxt_rdata;
      end
      error_o <= nxt_err;
      edge_select_o <= osp_ff[DCFG_ES_BIT];
      sync_tracking_enable_o <= osp_ff[DCFG_TRK_BIT];
      sync_encoding_enable_o <= osp_ff[DCFG_ENC_BIT];
      error_protect_select_o <= osp_ff[1:0];
      interleave_words_o <= (osp_ff[1:0] == DCFG_EDC_HAMMING) ?
                            DCFG_INTERLEAVE_WORDS : 5'h00;
      double_mode_o <= mode_ff[DCFG_DBL_BIT];
      double_mode_equal_o <= inv_ff[DCFG_EQDBL_BIT];
      stagger_disable_o <= inv_ff[DCFG_STAG_BIT];
    end
  end

  // Video inversion: syncs when encoding on, data bits otherwise
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      vsync_o <= 1'b0;
      hsync_o <= 1'b0;
      output_bit_zero_o <= 1'b0;
      output_bit_one_o <= 1'b0;
    end else if (en_i) begin
      vsync_o <= vsync_i ^ (inv_ff[DCFG_VINV_BIT] & osp_ff[DCFG_ENC_BIT]);
      hsync_o <= hsync_i ^ (inv_ff[DCFG_HINV_BIT] & osp_ff[DCFG_ENC_BIT]);
      output_bit_zero_o <= data_low_i[0] ^
                           (inv_ff[DCFG_VINV_BIT] & !osp_ff[DCFG_ENC_BIT]);
      output_bit_one_o <= data_low_i[1] ^
                          (inv_ff[DCFG_HINV_BIT] & !osp_ff[DCFG_ENC_BIT]);
    end
  end

  dcfg_xlate u_xlate (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .en_i(en_i),
    .addr_valid_i(xl_valid_i),
    .addr_i(xl_addr_i),
    .src_a_i(src_a_ff),
    .dst_a_i(dst_a_ff),
    .src_b_i(src_b_ff),
    .dst_b_i(dst_b_ff),
    .addr_valid_o(xl_valid_o),
    .addr_o(xl_addr_o)
  );
endmodule

// ### hw/dcfg_pkg.sv
// Package for the deserializer output/error configuration register bank.
// Assumes a byte-wide register port from the control-channel decoder.
// How it works
// - Edge select zero means rising-edge output.
// - D3 enables sync tracking, strap default.
// - D2 enables sync encoding, strap default.
// - Two-bit field picks parity, CRC, Hamming.
// - Hamming interleaves 16 words; strap default.
// - D7 inverts vertical sync or bit zero.
// - D6 inverts horizontal sync or bit one.
// - Auto-clear counters 1 us after error.
// - Error-select field picks the error source.
// - Translator pair A, bits 7:1, reset zero.
// - Translator pair B, bits 7:1, reset zero.
// - D7 selects double mode, strap default.
// - Writable detected-error threshold, reset zero.
// - Writable corrected-error threshold, reset zero.
package dcfg_pkg;
  localparam logic [7:0] DCFG_ADDR_MODE = 8'h06;
  localparam logic [7:0] DCFG_ADDR_OSP = 8'h07;
  localparam logic [7:0] DCFG_ADDR_INV = 8'h08;
  localparam logic [7:0] DCFG_ADDR_SRCA = 8'h09;
  localparam logic [7:0] DCFG_ADDR_DSTA = 8'h0A;
  localparam logic [7:0] DCFG_ADDR_SRCB = 8'h0B;
  localparam logic [7:0] DCFG_ADDR_DSTB = 8'h0C;
  localparam logic [7:0] DCFG_ADDR_DETTH = 8'h0F;
  localparam logic [7:0] DCFG_ADDR_DETCNT = 8'h10;
  localparam logic [7:0] DCFG_ADDR_CORTH = 8'h11;
  localparam logic [7:0] DCFG_ADDR_CORCNT = 8'h12;
  // Field positions
  localparam int DCFG_DBL_BIT = 7;
  localparam int DCFG_ES_BIT = 4;
  localparam int DCFG_TRK_BIT = 3;
  localparam int DCFG_ENC_BIT = 2;
  localparam int DCFG_VINV_BIT = 7;
  localparam int DCFG_HINV_BIT = 6;
  localparam int DCFG_EQDBL_BIT = 4;
  localparam int DCFG_STAG_BIT = 3;
  localparam int DCFG_AUTO_BIT = 2;
  // Protection schemes
  localparam logic [1:0] DCFG_EDC_PARITY = 2'h0;
  localparam logic [1:0] DCFG_EDC_CRC = 2'h1;
  localparam logic [1:0] DCFG_EDC_HAMMING = 2'h2;
  localparam logic [4:0] DCFG_INTERLEAVE_WORDS = 5'h10;
  // Error source select
  localparam logic [1:0] DCFG_ERROR_OUTPUT_SELECT_DET = 2'h0;
  localparam logic [1:0] DCFG_ERROR_OUTPUT_SELECT_COR = 2'h1;
  // Reset values
  localparam logic [7:0] DCFG_RST_ZERO = 8'h00;
  // Auto-clear delay
  localparam int DCFG_CLK_MHZ = 100;
  localparam int DCFG_AUTOCLR_US = 1;
  localparam int DCFG_AUTOCLR_CYC = DCFG_AUTOCLR_US * DCFG_CLK_MHZ;
  localparam int DCFG_XLATE_CNT = 2;
  typedef enum logic [2:0] {
    DCFG_ST_IDLE = 3'b001,
    DCFG_ST_WAIT = 3'b010,
    DCFG_ST_HOLD = 3'b100
  } dcfg_clr_state_t;
endpackage

// ### hw/dcfg_xlate.sv
// I2C address translator: two source/destination pairs.
// Assumes registers are stable while a transaction is forwarded.
`timescale 1ns/1ps
module dcfg_xlate
  import dcfg_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic en_i,
  // Address path
  input wire logic addr_valid_i,
  input wire logic [6:0] addr_i,
  input wire logic [6:0] src_a_i,
  input wire logic [6:0] dst_a_i,
  input wire logic [6:0] src_b_i,
  input wire logic [6:0] dst_b_i,
  output logic addr_valid_o,
  output logic [6:0] addr_o
);
  logic [6:0] nxt_addr;

  // Pair A wins when both sources match
  always_comb begin
    nxt_addr = addr_i;
    if (addr_i == src_b_i) begin
      nxt_addr = dst_b_i;
    end
    if (addr_i == src_a_i) begin
      nxt_addr = dst_a_i;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      addr_valid_o <= 1'b0;
      addr_o <= 7'h00;
    end else if (en_i) begin
      addr_valid_o <= addr_valid_i;
      if (addr_valid_i) begin
        addr_o <= nxt_addr;
      end
    end
  end
endmodule

// ### tb/dcfg_regs_checker.sv
// Port assertions for the configuration register bank.
// Assumes one clock domain; bound to every dcfg_regs instance.
`timescale 1ns/1ps
module dcfg_regs_checker
  import dcfg_pkg::*;
(
  // Clock, reset, register port
  input wire logic clk_i, nrst_i, en_i, reg_wr_i, reg_rd_i, reg_rvalid_o,
  input wire logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o,
  // Video, configuration, translator
  input wire logic [1:0] data_low_i, error_protect_select_o,
  input wire logic output_bit_zero_o, output_bit_one_o, edge_select_o, error_o,
  input wire logic sync_tracking_enable_o, sync_encoding_enable_o, double_mode_o,
  input wire logic double_mode_equal_o, stagger_disable_o, xl_valid_i, xl_valid_o,
  input wire logic [4:0] interleave_words_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // Register lands on the write edge, outputs follow one edge later
  sequence wr_to(logic [7:0] a);
    en_i && reg_wr_i && reg_addr_i == a ##1 en_i;
  endsequence
  a_osp_write_lands: assert property (wr_to(DCFG_ADDR_OSP) |=>
    {edge_select_o, sync_tracking_enable_o, sync_encoding_enable_o, error_protect_select_o}
    == $past(reg_wdata_i[4:0], 2)) else $error("output config not applied");
  a_mode_write_lands: assert property (wr_to(DCFG_ADDR_MODE) |=>
    double_mode_o == $past(reg_wdata_i[7], 2)) else $error("double mode not applied");
  a_inv_write_lands: assert property (wr_to(DCFG_ADDR_INV) |=>
    {double_mode_equal_o, stagger_disable_o} == $past(reg_wdata_i[4:3], 2))
    else $error("inversion register levels not applied");
  a_interleave_hamming: assert property (
    interleave_words_o == (error_protect_select_o == DCFG_EDC_HAMMING ? 5'h10 : 5'h00))
    else $error("interleave count wrong");
  a_read_answer: assert property ($past(en_i) |->
    reg_rvalid_o == $past(reg_rd_i)) else $error("read valid misplaced");
  a_reserved_zero: assert property (
    en_i && reg_rd_i && reg_addr_i inside {[8'h09:8'h0C]} |=> !reg_rdata_o[0])
    else $error("reserved bit reads one");
  a_xlate_latency: assert property (en_i |=> xl_valid_o == $past(xl_valid_i))
    else $error("translator valid latency");
  a_plain_data_bits: assert property (
    en_i && sync_encoding_enable_o ##1 en_i && sync_encoding_enable_o |->
    {output_bit_one_o, output_bit_zero_o} == $past(data_low_i)) else $error("data inverted");
  c_error_raised: cover property ($rose(error_o));
  c_hamming: cover property (interleave_words_o == 5'h10);
  c_translate: cover property (xl_valid_o);
endmodule

bind dcfg_regs dcfg_regs_checker i_dcfg_regs_checker (.*);

// ### tb/dcfg_host.sv
// Host model: byte reads and writes on the bank's register port.
// Assumes a read is answered by a valid pulse within four cycles.
`timescale 1ns/1ps
module dcfg_host (
  // Clock
  input wire logic clk_i,
  // Register port
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  input wire logic [7:0] reg_rdata_i,
  input wire logic reg_rvalid_i
);
  initial {reg_wr_o, reg_rd_o, reg_addr_o, reg_wdata_o} = 18'h0;
  // Callers touch edge select only with video idle, inversion only with
  // matching double modes, double-equal only with encoding off
  task automatic wr(input logic [7:0] a, d);
    @(negedge clk_i);
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    @(negedge clk_i);
    reg_wr_o = 1'b0;
    // Idle bus carries junk, never the last byte
    reg_addr_o = ~a;
    reg_wdata_o = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n = 0;
    @(negedge clk_i);
    reg_addr_o = a;
    reg_rd_o = 1'b1;
    @(negedge clk_i);
    reg_rd_o = 1'b0;
    reg_addr_o = ~a;
    while (reg_rvalid_i !== 1'b1 && n < 4) begin
      @(negedge clk_i);
      n++;
    end
    d = reg_rvalid_i === 1'b1 ? reg_rdata_i : 8'hXX;
  endtask
endmodule

// ### tb/dcfg_regs_test.sv
// Self-checking bench for the configuration register bank.
// Assumes the host model owns the register port; clock enable held high except in t_enable.
`timescale 1ns/1ps
module dcfg_regs_test
  import dcfg_pkg::*;
;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic en_i = 1'b1;
  logic local_control_enable_pin_i = 1'b1, edge_config_pin_i = 1'b0, sync_config_pin_i = 1'b0;
  logic protect_config_pin_i = 1'b0, double_config_pin_i = 1'b0, xl_valid_i = 1'b0;
  logic det_err_i = 1'b0, cor_err_i = 1'b0, vsync_i = 1'b0, hsync_i = 1'b0;
  logic [1:0] data_low_i = 2'h0;
  logic [6:0] xl_addr_i = 7'h00;
  logic reg_wr_i, reg_rd_i, reg_rvalid_o, vsync_o, hsync_o, output_bit_zero_o, output_bit_one_o;
  logic edge_select_o, sync_tracking_enable_o, sync_encoding_enable_o, double_mode_o, error_o;
  logic double_mode_equal_o, stagger_disable_o, xl_valid_o;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
  logic [1:0] error_protect_select_o;
  logic [4:0] interleave_words_o;
  logic [6:0] xl_addr_o;
  logic [4:0] osp_o;
  logic [3:0] vid_o;
  int err_count = 0;
  int tests_run = 0;
  int cycles = 0;
  assign osp_o = {edge_select_o, sync_tracking_enable_o, sync_encoding_enable_o,
    error_protect_select_o};
  assign vid_o = {hsync_o, vsync_o, output_bit_one_o, output_bit_zero_o};

  dcfg_regs i_dcfg_regs (.*);
  dcfg_host i_dcfg_host (.clk_i(clk_i), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i),
    .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i), .reg_rdata_i(reg_rdata_o),
    .reg_rvalid_i(reg_rvalid_o));

  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      wrap_up();
    end
  end

  task automatic check(input string nm, input logic [7:0] exp, got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s: expected %h, seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    i_dcfg_host.wr(a, d);
  endtask
  task automatic rdchk(input logic [7:0] a, exp);
    logic [7:0] d;
    i_dcfg_host.rd(a, d);
    check($sformatf("register %h", a), exp, d);
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic do_reset(input logic [4:0] p);
    @(negedge clk_i);
    nrst_i = 1'b0;
    {double_config_pin_i, protect_config_pin_i, sync_config_pin_i, edge_config_pin_i,
      local_control_enable_pin_i} = p;
    wait_n(5);
    nrst_i = 1'b1;
    wait_n(3);
  endtask
  task automatic errs(input logic [1:0] m, input int n);
    @(negedge clk_i);
    {cor_err_i, det_err_i} = m;
    wait_n(n);
    {cor_err_i, det_err_i} = 2'b00;
    wait_n(3);
  endtask

  task automatic t_straps();
    logic [7:0] r [10] = '{8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0F, 8'h10, 8'h11, 8'h12, 8'h20};
    do_reset(5'b11111);
    rdchk(DCFG_ADDR_OSP, 8'h00);
    check("double pin", 8'h00, 8'(double_mode_o));
    do_reset(5'b11110);
    rdchk(DCFG_ADDR_OSP, 8'h1E);
    check("double pin", 8'h01, 8'(double_mode_o));
    wr(8'h20, 8'hFF);
    foreach (r[i]) rdchk(r[i], 8'h00);
  endtask
  task automatic t_osp();
    logic [7:0] v [4] = '{8'hF2, 8'h09, 8'h0C, 8'h00};
    foreach (v[i]) begin
      wr(DCFG_ADDR_OSP, v[i]);
      wait_n(1);
      check("osp fields", v[i] & 8'h1F, 8'(osp_o));
      check("interleave", v[i][1:0] == 2'h2 ? 8'h10 : 8'h00, 8'(interleave_words_o));
      rdchk(DCFG_ADDR_OSP, v[i] & 8'h1F);
    end
    for (int i = 0; i < 2; i++) begin
      wr(DCFG_ADDR_MODE, i ? 8'h80 : 8'h00);
      wait_n(1);
      check("double mode", 8'(i), 8'(double_mode_o));
    end
  endtask
  task automatic t_inv();
    for (int e = 1; e >= 0; e--) begin
      wr(DCFG_ADDR_OSP, e ? 8'h0C : 8'h08);
      wr(DCFG_ADDR_INV, e ? 8'hC0 : 8'hD0);
      {vsync_i, hsync_i, data_low_i} = 4'b1001;
      wait_n(2);
      check("video out", e ? 8'h09 : 8'h06, 8'(vid_o));
      check("double equal", 8'(1 - e), 8'(double_mode_equal_o));
    end
    wr(DCFG_ADDR_INV, 8'h00);
    wait_n(2);
    check("video plain", 8'h05, 8'(vid_o));
  endtask
  task automatic t_err();
    int n = 0;
    wr(DCFG_ADDR_DETTH, 8'h02);
    wr(DCFG_ADDR_CORTH, 8'h01);
    errs(2'b01, 3);
    wr(DCFG_ADDR_INV, 8'h29);
    wait_n(3);
    check("error corrected", 8'h00, 8'(error_o));
    check("stagger", 8'h01, 8'(stagger_disable_o));
    rdchk(DCFG_ADDR_INV, 8'h09);
    wr(DCFG_ADDR_DETCNT, 8'h55);
    rdchk(DCFG_ADDR_DETCNT, 8'h03);
    wr(DCFG_ADDR_INV, 8'h00);
    wait_n(150);
    check("error detected", 8'h01, 8'(error_o));
    errs(2'b10, 2);
    wr(DCFG_ADDR_INV, 8'h01);
    wait_n(3);
    check("error corrected", 8'h01, 8'(error_o));
    rdchk(DCFG_ADDR_CORCNT, 8'h02);
    // Dropping the auto-clear bit mid-wait must leave the counters alone
    wr(DCFG_ADDR_INV, 8'h05);
    wait_n(50);
    wr(DCFG_ADDR_INV, 8'h01);
    wait_n(80);
    check("error after abort", 8'h01, 8'(error_o));
    rdchk(DCFG_ADDR_CORCNT, 8'h02);
    wr(DCFG_ADDR_INV, 8'h06);
    while (error_o === 1'b1 && n < 200) begin
      @(negedge clk_i);
      n++;
    end
    check("clear delay ok", 8'h01, 8'(n >= 95 && n <= 110));
    rdchk(DCFG_ADDR_DETCNT, 8'h00);
    rdchk(DCFG_ADDR_CORCNT, 8'h00);
    wr(DCFG_ADDR_INV, 8'h03);
    errs(2'b01, 3);
    check("error either", 8'h01, 8'(error_o));
  endtask
  task automatic t_enable();
    // Enable low: writes and error pulses must both be lost
    @(negedge clk_i);
    en_i = 1'b0;
    wr(DCFG_ADDR_DETTH, 8'h7E);
    errs(2'b11, 2);
    check("frozen error", 8'h01, 8'(error_o));
    en_i = 1'b1;
    rdchk(DCFG_ADDR_DETTH, 8'h02);
    rdchk(DCFG_ADDR_DETCNT, 8'h03);
    rdchk(DCFG_ADDR_CORCNT, 8'h00);
  endtask
  task automatic t_xlate();
    logic [6:0] want [3] = '{7'h31, 7'h32, 7'h23};
    wr(DCFG_ADDR_SRCA, 8'h43);
    wr(DCFG_ADDR_DSTA, 8'h63);
    wr(DCFG_ADDR_SRCB, 8'h45);
    wr(DCFG_ADDR_DSTB, 8'h65);
    rdchk(DCFG_ADDR_SRCA, 8'h42);
    rdchk(DCFG_ADDR_DSTB, 8'h64);
    foreach (want[i]) begin
      @(negedge clk_i);
      xl_valid_i = 1'b1;
      xl_addr_i = 7'h21 + 7'(i);
      @(negedge clk_i);
      xl_valid_i = 1'b0;
      xl_addr_i = ~xl_addr_i;
      check("translated", {1'b1, want[i]}, {xl_valid_o, xl_addr_o});
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    t_straps();
    t_osp();
    t_inv();
    t_err();
    t_enable();
    t_xlate();
    wrap_up();
  end
endmodule
